// ==== rtl/epp_pkg.sv ====
// package: register map, field layout and timing constants of the position logic
package epp_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned MS_NS = 1_000_000;
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_INT_PRESET = 12'h004;
    localparam logic [11:0] A_EXT_PRESET1 = 12'h008;
    localparam logic [11:0] A_EXT_PRESET2 = 12'h00C;
    localparam logic [11:0] A_DEBOUNCE = 12'h010;
    localparam logic [11:0] A_OFFSET = 12'h014;
    localparam logic [11:0] A_MULT = 12'h018;
    localparam logic [11:0] A_TURNS = 12'h01C;
    localparam logic [11:0] A_MSTEPS = 12'h020;
    localparam logic [11:0] A_STEPS = 12'h024;
    localparam logic [11:0] A_LIMIT0 = 12'h028;
    localparam logic [11:0] A_OVERSPEED = 12'h038;
    localparam logic [11:0] A_MARKCFG0 = 12'h03C;
    localparam logic [11:0] A_RAW = 12'h060;
    localparam logic [11:0] A_SPEED = 12'h064;
    localparam logic [11:0] A_POSITION = 12'h068;
    localparam logic [11:0] A_STATUS = 12'h06C;
    localparam logic [11:0] A_NVM = 12'h070;
    // control word fields
    localparam int unsigned C_EXT1_EN = 0;
    localparam int unsigned C_EXT2_EN = 1;
    localparam int unsigned C_LEN_EN = 2;
    localparam int unsigned C_REVERSE = 3;
    localparam int unsigned C_EXT_DIR_EN = 4;
    localparam int unsigned C_SCALE_LSB = 5;
    // marker config fields: [3:0] bit position, [4] active level, [5] enable
    localparam int unsigned M_ACT = 4;
    localparam int unsigned M_EN = 5;
    localparam int unsigned N_MARK = 9;
    localparam logic [3:0] POS_NONE = 4'h8;
    localparam logic [7:0] DEBOUNCE_RST = 8'hFF;
    localparam logic [23:0] MULT_ONE = 24'hFFFFFF;
    localparam logic [2:0] CTRL_RST = 3'h0;
    typedef enum logic [1:0] {SC_FACTOR, SC_TURNS, SC_MSTEPS} epp_scale_type;
    typedef enum {DV_IDLE, DV_RUN} epp_div_st_type;
endpackage

// ==== rtl/epp_div_if.sv ====
// interface: request and result of the multiplier divider
`timescale 1ns/1ps
`default_nettype none
interface epp_div_if;
    logic start;
    logic [47:0] num;
    logic [23:0] den;
    logic busy;
    logic done;
    logic [23:0] quo;
    modport master(output start, output num, output den,
                   input busy, input done, input quo);
    modport slave(input start, input num, input den,
                  output busy, output done, output quo);
endinterface
`default_nettype wire

// ==== rtl/epp_div.sv ====
// module: sequential divider that derives the resolution multiplier
`timescale 1ns/1ps
`default_nettype none
module epp_div
    import epp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    epp_div_if.slave dv
);
    epp_div_st_type st_q;
    logic [47:0] rem_q;
    logic [47:0] quo_q;
    logic [23:0] den_q;
    logic [5:0] cnt_q;
    logic [48:0] trial;
    logic done_q;

    // one quotient bit a cycle: slow but small
    assign trial = {rem_q, quo_q[47]} - {25'h0000000, den_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= DV_IDLE;
            rem_q <= 48'h0;
            quo_q <= 48'h0;
            den_q <= 24'h0;
            cnt_q <= 6'h0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (st_q)
                DV_IDLE:
                begin
                    if (dv.start)
                    begin
                        rem_q <= 48'h0;
                        quo_q <= dv.num;
                        den_q <= dv.den;
                        cnt_q <= 6'h30;
                        st_q <= DV_RUN;
                    end
                end
                DV_RUN:
                begin
                    if (!trial[48])
                    begin
                        rem_q <= trial[47:0];
                        quo_q <= {quo_q[46:0], 1'b1};
                    end
                    else
                    begin
                        rem_q <= {rem_q[46:0], quo_q[47]};
                        quo_q <= {quo_q[46:0], 1'b0};
                    end
                    cnt_q <= cnt_q - 6'h1;
                    if (cnt_q == 6'h1)
                    begin
                        st_q <= DV_IDLE;
                        done_q <= 1'b1;
                    end
                end
                default: st_q <= DV_IDLE;
            endcase
        end
    end

    assign dv.busy = (st_q == DV_RUN);
    assign dv.done = done_q;
    // quotients of one or above saturate to the largest multiplier
    assign dv.quo = (quo_q[47:24] != 24'h0) ? MULT_ONE : quo_q[23:0];
endmodule
`default_nettype wire

// ==== rtl/epp_core.sv ====
// module: position presets, offset, scaling, limits and status byte
//
// Summary of operation
// - writing the internal preset loads the position with it at once
// - debounced external preset pulse loads the position with its own preset
// - an external preset writes the resulting value to nonvolatile memory
// - each external preset input has an enable; disabled inputs are ignored
// - debounce time 1 to 255 ms, default 255 ms
// - offset write shifts position and keeps shifting later values
// - every preset clears the offset to zero
// - length mode: input 1 pulse starts measurement with preset 1
// - length mode: input 2 pulse freezes the result while it lasts
// - position times 3-byte unsigned fraction; largest value means one
// - resolution set by factor, by turns and steps, or measuring steps
// - turns 1..FFF with steps 0..FFFFFF: block computes the multiplier
// - measuring steps 1..FFFFFF with steps: block computes the multiplier
// - four 3-byte soft limits, each switchable on or off
// - enabled limit reached raises its marker for the status byte
// - each marker has a status bit position; 8 means unassigned
// - each marker has an active level of 0 or 1
// - overspeed threshold 0..255 in 100 rpm; reached and enabled sets marker
// - standstill, parity, error, direction markers each mappable
// - internal count direction plus enable for external direction input
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module epp_core
    import epp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_preset1,
    input wire logic ext_preset2,
    input wire logic ext_dir,
    input wire logic standstill,
    input wire logic parity_err,
    input wire logic encoder_err,
    input wire logic dir_fault,
    output logic [23:0] position,
    output logic [7:0] status_byte,
    output logic nvm_write,
    output logic [23:0] nvm_data
);
    logic [4:0] ctrl_q;
    epp_scale_type scale_q;
    logic [23:0] int_pre_q;
    logic [23:0] ext_pre_q [2];
    logic [7:0] deb_ms_q;
    logic [23:0] offset_q;
    logic [23:0] mult_q;
    logic [11:0] turns_q;
    logic [23:0] msteps_q;
    logic [23:0] steps_q;
    logic [23:0] limit_q [4];
    logic [7:0] ospeed_q;
    logic [5:0] mcfg_q [N_MARK];
    logic [23:0] raw_q;
    logic [15:0] speed_q;
    logic [23:0] base_q;
    logic [23:0] pos_q;
    logic [7:0] stat_q;
    logic nvm_q;
    logic [23:0] nvm_data_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [2:0] sync_q [3];
    logic [2:0] in_q;
    logic [2:0] pin_s;
    logic [15:0] ms_cnt_q [2];
    logic [7:0] deb_cnt_q [2];
    logic [1:0] trig_q;
    logic [1:0] fired_q;
    logic wr;
    logic rd;
    logic [23:0] raw_scaled;
    logic [47:0] prod;
    logic [23:0] scaled;
    logic [N_MARK-1:0] cond;
    logic [7:0] stat_d;
    logic div_pend_q;
    epp_div_if dv();

    function automatic logic [23:0] low24(input logic [31:0] v);
        return v[23:0];
    endfunction

    assign wr = psel && penable && pwrite && !pready_q;
    assign rd = psel && penable && !pwrite && !pready_q;

    // apb: one wait state, answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && (paddr > A_NVM);
            if (rd)
            begin
                case (paddr)
                    A_CTRL: prdata_q <= {25'h0, scale_q, ctrl_q};
                    A_INT_PRESET: prdata_q <= {8'h0, int_pre_q};
                    A_EXT_PRESET1: prdata_q <= {8'h0, ext_pre_q[0]};
                    A_EXT_PRESET2: prdata_q <= {8'h0, ext_pre_q[1]};
                    A_DEBOUNCE: prdata_q <= {24'h0, deb_ms_q};
                    A_OFFSET: prdata_q <= {8'h0, offset_q};
                    A_MULT: prdata_q <= {7'h0, div_pend_q, mult_q};
                    A_TURNS: prdata_q <= {20'h0, turns_q};
                    A_MSTEPS: prdata_q <= {8'h0, msteps_q};
                    A_STEPS: prdata_q <= {8'h0, steps_q};
                    A_OVERSPEED: prdata_q <= {24'h0, ospeed_q};
                    A_SPEED: prdata_q <= {16'h0, speed_q};
                    A_POSITION: prdata_q <= {8'h0, pos_q};
                    A_STATUS: prdata_q <= {24'h0, stat_q};
                    A_NVM: prdata_q <= {8'h0, nvm_data_q};
                    default:
                    begin
                        if (paddr >= A_LIMIT0 && paddr < A_OVERSPEED)
                            prdata_q <= {8'h0, limit_q[paddr[3:2] + 2'h2]};
                        else if (paddr >= A_MARKCFG0 && paddr < A_RAW)
                            prdata_q <= {26'h0,
                                mcfg_q[4'((paddr - A_MARKCFG0) >> 2)]};
                        else
                            prdata_q <= 32'h0;
                    end
                endcase
            end
        end
    end

    // three-stage synchronisers on the asynchronous pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_q[0] <= 3'h0;
            sync_q[1] <= 3'h0;
            sync_q[2] <= 3'h0;
            in_q <= 3'h0;
        end
        else
        begin
            sync_q[0] <= {ext_dir, ext_preset2, ext_preset1};
            sync_q[1] <= sync_q[0];
            sync_q[2] <= sync_q[1];
            for (int i = 0; i < 3; i++)
                if (sync_q[1][i] == sync_q[2][i])
                    in_q[i] <= sync_q[2][i];
        end
    end
    assign pin_s = in_q;

    // debounce: a pulse must outlast the programmed millisecond count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                ms_cnt_q[i] <= 16'h0;
                deb_cnt_q[i] <= 8'h0;
                fired_q[i] <= 1'b0;
                trig_q[i] <= 1'b0;
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                trig_q[i] <= 1'b0;
                if (!pin_s[i] || !ctrl_q[i])
                begin
                    ms_cnt_q[i] <= 16'h0;
                    deb_cnt_q[i] <= 8'h0;
                    fired_q[i] <= 1'b0;
                end
                else if (!fired_q[i])
                begin
                    if (ms_cnt_q[i] == 16'(CYC_PER_MS - 1))
                    begin
                        ms_cnt_q[i] <= 16'h0;
                        deb_cnt_q[i] <= deb_cnt_q[i] + 8'h1;
                        if (deb_cnt_q[i] + 8'h1 == deb_ms_q)
                        begin
                            fired_q[i] <= 1'b1;
                            trig_q[i] <= 1'b1;
                        end
                    end
                    else
                        ms_cnt_q[i] <= ms_cnt_q[i] + 16'h1;
                end
            end
        end
    end

    // configuration writes; presets clear the offset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= {2'h0, CTRL_RST};
            scale_q <= SC_FACTOR;
            int_pre_q <= 24'h0;
            ext_pre_q[0] <= 24'h0;
            ext_pre_q[1] <= 24'h0;
            deb_ms_q <= DEBOUNCE_RST;
            offset_q <= 24'h0;
            turns_q <= 12'h1;
            msteps_q <= 24'h1;
            steps_q <= 24'h0;
            ospeed_q <= 8'h0;
            for (int i = 0; i < 4; i++)
                limit_q[i] <= 24'h0;
            for (int i = 0; i < N_MARK; i++)
                mcfg_q[i] <= {2'b00, POS_NONE};
        end
        else
        begin
            if (wr)
            begin
                case (paddr)
                    A_CTRL:
                    begin
                        ctrl_q <= pwdata[4:0];
                        if (pwdata[6:5] != 2'h3)
                            scale_q <= epp_scale_type'(pwdata[6:5]);
                    end
                    A_INT_PRESET: int_pre_q <= low24(pwdata);
                    A_EXT_PRESET1: ext_pre_q[0] <= low24(pwdata);
                    A_EXT_PRESET2: ext_pre_q[1] <= low24(pwdata);
                    A_DEBOUNCE:
                        if (pwdata[7:0] != 8'h0)
                            deb_ms_q <= pwdata[7:0];
                    A_OFFSET: offset_q <= low24(pwdata);
                    A_TURNS:
                        if (pwdata[11:0] != 12'h0)
                            turns_q <= pwdata[11:0];
                    A_MSTEPS:
                        if (low24(pwdata) != 24'h0)
                            msteps_q <= low24(pwdata);
                    A_STEPS: steps_q <= low24(pwdata);
                    A_OVERSPEED: ospeed_q <= pwdata[7:0];
                    default:
                    begin
                        if (paddr >= A_LIMIT0 && paddr < A_OVERSPEED)
                            limit_q[paddr[3:2] + 2'h2] <= low24(pwdata);
                        else if (paddr >= A_MARKCFG0 && paddr < A_RAW)
                            mcfg_q[4'((paddr - A_MARKCFG0) >> 2)] <=
                                pwdata[5:0];
                    end
                endcase
            end
            if ((wr && paddr == A_INT_PRESET) || trig_q[0] ||
                (trig_q[1] && !ctrl_q[C_LEN_EN]))
                offset_q <= 24'h0;
        end
    end

    // multiplier: direct write, or derived by division
    assign dv.start = div_pend_q && !dv.busy && !dv.done;
    assign dv.num = {steps_q, 24'h0};
    assign dv.den = (scale_q == SC_TURNS) ? {turns_q, 12'h0} : msteps_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mult_q <= MULT_ONE;
            div_pend_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr == A_MULT)
                mult_q <= low24(pwdata);
            else if (dv.done && scale_q != SC_FACTOR)
                mult_q <= dv.quo;
            if (dv.start)
                div_pend_q <= 1'b0;
            if (wr && (paddr == A_TURNS || paddr == A_MSTEPS ||
                paddr == A_STEPS || paddr == A_CTRL))
                div_pend_q <= 1'b1;
        end
    end

    epp_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .dv(dv)
    );

    // scale before reversing: the product is unsigned, so a negated
    // count would be scaled as a huge value
    assign prod = raw_q * ((mult_q == MULT_ONE) ? 24'h0 : mult_q);
    assign raw_scaled = (mult_q == MULT_ONE) ? raw_q : prod[47:24];
    assign scaled = (ctrl_q[C_REVERSE] ^ (ctrl_q[C_EXT_DIR_EN] & pin_s[2]))
        ? 24'(-raw_scaled) : raw_scaled;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_q <= 24'h0;
            speed_q <= 16'h0;
            base_q <= 24'h0;
            pos_q <= 24'h0;
            nvm_q <= 1'b0;
            nvm_data_q <= 24'h0;
        end
        else
        begin
            nvm_q <= 1'b0;
            if (wr && paddr == A_RAW)
                raw_q <= low24(pwdata);
            if (wr && paddr == A_SPEED)
                speed_q <= pwdata[15:0];
            if (wr && paddr == A_INT_PRESET)
                base_q <= scaled - low24(pwdata);
            else if (trig_q[0])
                base_q <= scaled - ext_pre_q[0];
            else if (trig_q[1] && !ctrl_q[C_LEN_EN])
                base_q <= scaled - ext_pre_q[1];
            if (trig_q[0] || (trig_q[1] && !ctrl_q[C_LEN_EN]))
            begin
                nvm_q <= 1'b1;
                nvm_data_q <= trig_q[0] ? ext_pre_q[0] : ext_pre_q[1];
            end
            // frozen while input 2 is held in length mode
            if (!(ctrl_q[C_LEN_EN] && ctrl_q[C_EXT2_EN] && pin_s[1]))
                pos_q <= scaled - base_q + offset_q;
        end
    end

    // marker conditions and status byte
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            cond[i] = (pos_q == limit_q[i]);
        cond[4] = (speed_q >= {ospeed_q, 8'h0} - 16'(ospeed_q) * 16'd156)
            && (speed_q >= 16'(ospeed_q) * 16'd100);
        cond[5] = standstill;
        cond[6] = parity_err;
        cond[7] = encoder_err;
        cond[8] = dir_fault;
        stat_d = 8'h0;
        for (int i = 0; i < N_MARK; i++)
            if (mcfg_q[i][M_EN] && mcfg_q[i][3:0] < POS_NONE)
                stat_d[mcfg_q[i][2:0]] =
                    mcfg_q[i][M_ACT] ~^ cond[i];
    end

    // bits with a source idle at the inverse of their active level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= 8'h0;
        else
            stat_q <= stat_d;
    end

    assign position = pos_q;
    assign status_byte = stat_q;
    assign nvm_write = nvm_q;
    assign nvm_data = nvm_data_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    property p_preset_int;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == A_INT_PRESET) |=> offset_q == 24'h0;
    endproperty
    a_preset_int: assert property (p_preset_int)
        else $error("offset not cleared by preset");

    property p_nvm;
        @(posedge pclk) disable iff (!presetn)
        trig_q[0] |=> nvm_write && nvm_data == $past(ext_pre_q[0]);
    endproperty
    a_nvm: assert property (p_nvm)
        else $error("external preset not stored");

    property p_disabled;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_q[C_EXT1_EN] |=> !trig_q[0];
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled input fired");

    property p_deb;
        @(posedge pclk) disable iff (!presetn)
        deb_ms_q != 8'h0;
    endproperty
    a_deb: assert property (p_deb)
        else $error("debounce time out of range");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_q[C_LEN_EN] && ctrl_q[C_EXT2_EN] && pin_s[1]) |=>
            $stable(pos_q);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("position moved while frozen");

    property p_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb answer late");

    property p_ext_load;
        @(posedge pclk) disable iff (!presetn)
        (trig_q[0] && !(wr && paddr == A_INT_PRESET)) |=> ##1
            (ctrl_q[C_LEN_EN] && pin_s[1]) || pos_q == $past(ext_pre_q[0], 2)
            || $changed(raw_q) || $changed(ctrl_q) || $changed(mult_q);
    endproperty
    a_ext_load: assert property (p_ext_load)
        else $error("external preset not loaded");

    property p_unassigned;
        @(posedge pclk) disable iff (!presetn)
        (mcfg_q[0][3:0] == POS_NONE && mcfg_q[1][3:0] == POS_NONE &&
         mcfg_q[2][3:0] == POS_NONE && mcfg_q[3][3:0] == POS_NONE &&
         mcfg_q[4][3:0] == POS_NONE && mcfg_q[5][3:0] == POS_NONE &&
         mcfg_q[6][3:0] == POS_NONE && mcfg_q[7][3:0] == POS_NONE &&
         mcfg_q[8][3:0] == POS_NONE) |=> status_byte == 8'h0;
    endproperty
    a_unassigned: assert property (p_unassigned)
        else $error("unassigned status bit driven");
endmodule
`default_nettype wire

// ==== test/epp_pin_drv.sv ====
// partner model: external preset pin driven by the field wiring
`timescale 1ns/1ps
`default_nettype none
module epp_pin_drv
(
    input wire logic pclk,
    output logic pin
);
    initial pin = 1'b0;
    // pulse of a given length; the pin rests low between pulses
    task automatic pulse(input int cycles);
        @(posedge pclk);
        pin <= 1'b1;
        repeat (cycles) @(posedge pclk);
        pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== test/encoder_position_param_logic_tb.sv ====
// testbench: register access, presets, offset, status byte, external preset
`timescale 1ns/1ps
`default_nettype none
module encoder_position_param_logic_tb;
    import epp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, ext1, ext_dir = 1'b0;
    logic ext2 = 1'b0, standstill = 1'b0, parity_err = 1'b0;
    logic encoder_err = 1'b0, dir_fault = 1'b0, nvm_write;
    logic [23:0] position, nvm_data, nvm_val;
    logic [7:0] status_byte;
    int num_errors = 0, num_checks = 0, nvm_cnt = 0;
    always #10 pclk = ~pclk;
    epp_pin_drv pin1 (.pclk(pclk), .pin(ext1));
    epp_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_preset1(ext1), .ext_preset2(ext2), .ext_dir(ext_dir),
        .standstill(standstill), .parity_err(parity_err),
        .encoder_err(encoder_err), .dir_fault(dir_fault),
        .position(position), .status_byte(status_byte),
        .nvm_write(nvm_write), .nvm_data(nvm_data));
    always @(posedge pclk)
        if (nvm_write === 1'b1)
        begin
            nvm_cnt++;
            nvm_val = nvm_data;
        end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the request is held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // a slave that never answers is ended by the watchdog
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // the debounce test alone needs about 50k cycles
    initial
    begin
        repeat (70000) @(posedge pclk);
        num_errors++;
        final_report();
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(A_DEBOUNCE, 32'hFF);
        rchk(A_MULT, 32'h00FFFFFF);
        rchk(A_MARKCFG0, 32'h8);
        rchk(12'h074, 32'h0);
        chk(er, 1'b1);
        $display("test reset values done");
        apb(1'b1, A_INT_PRESET, 32'h1234);
        rchk(A_POSITION, 32'h1234);
        apb(1'b1, A_OFFSET, 32'h10);
        rchk(A_POSITION, 32'h1244);
        apb(1'b1, A_INT_PRESET, 32'h100);
        rchk(A_POSITION, 32'h100);
        $display("test preset and offset done");
        apb(1'b1, A_LIMIT0, 32'h100);
        apb(1'b1, A_MARKCFG0, 32'h35);
        apb(1'b1, A_MARKCFG0 + 12'h014, 32'h33);
        apb(1'b1, A_MARKCFG0 + 12'h018, 32'h26);
        apb(1'b1, A_OVERSPEED, 32'd47);
        apb(1'b1, A_MARKCFG0 + 12'h010, 32'h30);
        apb(1'b1, A_SPEED, 32'd4700);
        standstill <= 1'b1;
        rchk(A_STATUS, 32'h69);
        chk(status_byte, 8'h69);
        standstill <= 1'b0;
        parity_err <= 1'b1;
        apb(1'b1, A_SPEED, 32'd4600);
        rchk(A_STATUS, 32'h20);
        $display("test status byte done");
        apb(1'b1, A_EXT_PRESET1, 32'hABC);
        apb(1'b1, A_DEBOUNCE, 32'h1);
        apb(1'b1, A_CTRL, 32'h1);
        apb(1'b1, A_OFFSET, 32'h5);
        pin1.pulse(200);
        rchk(A_POSITION, 32'h105);
        chk(nvm_cnt, 0);
        pin1.pulse(CYC_PER_MS + 100);
        repeat (5) @(posedge pclk);
        rchk(A_POSITION, 32'hABC);
        chk(nvm_cnt, 1);
        chk(nvm_val, 24'hABC);
        $display("test external preset done");
        apb(1'b1, A_CTRL, 32'h41);
        apb(1'b1, A_MSTEPS, 32'h2);
        apb(1'b1, A_STEPS, 32'h1);
        // two divisions of 48 steps each may still be queued
        repeat (120) @(posedge pclk);
        rchk(A_MULT, 32'h00800000);
        apb(1'b1, A_RAW, 32'h200);
        rchk(A_POSITION, 32'hBBC);
        apb(1'b1, A_CTRL, 32'h48);
        rchk(A_POSITION, 32'h9BC);
        apb(1'b1, A_CTRL, 32'h50);
        ext_dir <= 1'b1;
        repeat (5) @(posedge pclk);
        rchk(A_POSITION, 32'h9BC);
        $display("test scaling and direction done");
        apb(1'b1, A_CTRL, 32'h46);
        ext2 <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b1, A_RAW, 32'h400);
        rchk(A_POSITION, 32'hBBC);
        ext2 <= 1'b0;
        repeat (5) @(posedge pclk);
        rchk(A_POSITION, 32'hCBC);
        chk(position, 24'hCBC);
        $display("test length freeze done");
        final_report();
    end
endmodule
`default_nettype wire
